// ---- verilog/dac_loader_pkg.sv ----
package dac_loader_pkg;

	// Program window on the processor bus
	localparam logic [15:0] WINDOW_FIRST = 16'h4800;
	localparam logic [15:0] WINDOW_LAST = 16'h4BFF;
	localparam int PROGRAM_WORDS = 1024;
	localparam int PROGRAM_ADDR_BITS = 10;

	// Display and selection geometry
	localparam int DISPLAY_DIGITS = 12;
	localparam logic [3:0] POSITION_FIRST = 4'h1;
	localparam logic [3:0] POSITION_LAST = 4'hC;
	localparam logic [3:0] NUMERAL_LAST = 4'h9;
	localparam logic [7:0] ERROR_CODE = 8'h0A;

	// Converter word layout
	localparam int WORD_BITS = 12;
	localparam logic [11:0] WORD_RESET = 12'h000;
	localparam logic [11:0] RAMP_LAST = 12'h999;
	localparam logic [3:0] BCD_LAST = 4'h9;

	// Keys as decoded by the keypad scanner
	typedef enum logic [3:0]
	{
		KEY_DIGIT,
		KEY_FUNCTION,
		KEY_CLEAR,
		KEY_OFF,
		KEY_OTHER
	} keyCode_type;

	typedef struct packed
	{
		logic press;
		logic keyUp;
		keyCode_type code;
		logic [3:0] digit;
	} keyEvent_type;

	// What the display shows for the converter function
	typedef enum logic [2:0]
	{
		SHOW_NORMAL,
		SHOW_STATUS,
		SHOW_PARTIAL,
		SHOW_NEW,
		SHOW_ERROR
	} showMode_type;

	typedef struct packed
	{
		showMode_type mode;
		logic statusOn;
		logic [3:0] tens;
		logic [3:0] units;
		logic [7:0] errorCode;
		logic [11:0] markers;
	} panel_type;

	// Parallel port lines toward the holding latch
	typedef struct packed
	{
		logic [7:0] portA;
		logic [3:0] portB;
		logic strobe;
	} portLines_type;

endpackage

// ---- verilog/program_window.sv ----
`timescale 1ns/1ns

module program_window
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Processor bus
	input wire logic [15:0] procAddr,
	input wire logic procRead,
	output logic [7:0] procDataOut,
	output logic procDataOe,
	// Program loading port
	input wire logic progWrite,
	input wire logic [dac_loader_pkg::PROGRAM_ADDR_BITS-1:0] progAddr,
	input wire logic [7:0] progData
);

	logic [7:0] programMem [dac_loader_pkg::PROGRAM_WORDS];
	logic [7:0] readData_r;
	logic [7:0] readData_nxt;
	logic driveOe_r;
	logic driveOe_nxt;
	logic hit;

	// Address compare for the program window
	function automatic logic inWindow(input logic [15:0] addr);
		return (addr >= dac_loader_pkg::WINDOW_FIRST) && (addr <= dac_loader_pkg::WINDOW_LAST);
	endfunction

	assign hit = procRead && inWindow(procAddr);

	// Program storage, written through the loading port
	always_ff @(posedge clock)
	begin
		if (progWrite)
			programMem[progAddr] <= progData;
	end

	// Read data and bus drive for the next cycle
	always_comb
	begin
		readData_nxt = readData_r;
		driveOe_nxt = hit;
		if (hit)
			readData_nxt = programMem[procAddr[dac_loader_pkg::PROGRAM_ADDR_BITS-1:0]];
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			readData_r <= 8'h00;
			driveOe_r <= 1'b0;
		end
		else
		begin
			readData_r <= readData_nxt;
			driveOe_r <= driveOe_nxt;
		end
	end

	assign procDataOut = readData_r;
	assign procDataOe = driveOe_r;

	AST_WINDOW_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
		procDataOe |-> $past(procRead) && ($past(procAddr) >= 16'h4800) && ($past(procAddr) <= 16'h4BFF))
		else $error("bus driven outside program window");

	AST_WINDOW_DRIVES: assert property (@(posedge clock) disable iff (!reset_n)
		(procRead && procAddr == 16'h4800) |=> procDataOe)
		else $error("window read not answered");

endmodule

// ---- verilog/display_digit_dac_loader.sv ----
`timescale 1ns/1ns

module display_digit_dac_loader
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Processor bus toward the program window
	input wire logic [15:0] procAddr,
	input wire logic procRead,
	output logic [7:0] procDataOut,
	output logic procDataOe,
	// Program loading port
	input wire logic progWrite,
	input wire logic [dac_loader_pkg::PROGRAM_ADDR_BITS-1:0] progAddr,
	input wire logic [7:0] progData,
	// Display contents, position 1 in the top nibble
	input wire logic [dac_loader_pkg::DISPLAY_DIGITS-1:0][3:0] displayChars,
	input wire logic displayRefresh,
	// Keypad
	input wire dac_loader_pkg::keyEvent_type keyEvent,
	// Test switch from a pin
	input wire logic rampTestPin,
	// Display status toward the panel
	output dac_loader_pkg::panel_type panel,
	output logic dacEnabled,
	output logic [3:0] dacPosition,
	// Parallel port lines and the converter latch
	output dac_loader_pkg::portLines_type portLines,
	output logic [11:0] dacWord
);

	typedef enum logic [1:0]
	{
		SQ_IDLE,
		SQ_LOW,
		SQ_HIGH
	} seqState_type;

	dac_loader_pkg::showMode_type showMode_r, showMode_nxt;
	logic enable_r, enable_nxt;
	logic [3:0] position_r, position_nxt;
	logic [3:0] tens_r, tens_nxt;
	logic [3:0] units_r, units_nxt;
	seqState_type seqState_r, seqState_nxt;
	logic pending_r, pending_nxt;
	logic [11:0] wordPend_r, wordPend_nxt;
	logic [11:0] ramp_r, ramp_nxt;
	logic [7:0] portA_r, portA_nxt;
	logic [3:0] portB_r, portB_nxt;
	logic strobe_r, strobe_nxt;
	logic [11:0] latch_r, latch_nxt;
	logic testMeta_r, testSync_r;
	logic [11:0] selectedWord;
	logic [11:0] markerMask;
	logic [7:0] entryValue;
	logic startLoad;

	// Character at a position, blank beyond the right edge
	function automatic logic [3:0] charAt(input logic [dac_loader_pkg::DISPLAY_DIGITS-1:0][3:0] chars,
		input logic [4:0] pos);
		if (pos >= 5'd1 && pos <= 5'(dac_loader_pkg::DISPLAY_DIGITS))
			return chars[4'(5'(dac_loader_pkg::DISPLAY_DIGITS) - pos)];
		return 4'hF;
	endfunction

	// Non-numeral characters count as zero
	function automatic logic [3:0] digitValue(input logic [3:0] c);
		return (c > dac_loader_pkg::NUMERAL_LAST) ? 4'h0 : c;
	endfunction

	// Three-digit BCD increment with wrap after 999
	function automatic logic [11:0] bcdInc(input logic [11:0] v);
		logic [11:0] r;
		r = v;
		if (v == dac_loader_pkg::RAMP_LAST)
			r = dac_loader_pkg::WORD_RESET;
		else if (v[3:0] != dac_loader_pkg::BCD_LAST)
			r[3:0] = v[3:0] + 4'h1;
		else if (v[7:4] != dac_loader_pkg::BCD_LAST)
			r = {v[11:8], v[7:4] + 4'h1, 4'h0};
		else
			r = {v[11:8] + 4'h1, 8'h00};
		return r;
	endfunction

	// Program memory window on the processor bus
	program_window programWindow
	(
		.clock(clock),
		.reset_n(reset_n),
		.procAddr(procAddr),
		.procRead(procRead),
		.procDataOut(procDataOut),
		.procDataOe(procDataOe),
		.progWrite(progWrite),
		.progAddr(progAddr),
		.progData(progData)
	);

	// Test switch comes from a pin, two flops before use
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			testMeta_r <= 1'b0;
			testSync_r <= 1'b0;
		end
		else
		begin
			testMeta_r <= rampTestPin;
			testSync_r <= testMeta_r;
		end
	end

	// Word picked from the display, top digit at the selected position
	assign selectedWord = {digitValue(charAt(displayChars, {1'b0, position_r})),
		digitValue(charAt(displayChars, 5'({1'b0, position_r} + 5'd1))),
		digitValue(charAt(displayChars, 5'({1'b0, position_r} + 5'd2)))};

	// Decimal point markers over the three selected digits
	generate
		for (genvar i = 0; i < dac_loader_pkg::DISPLAY_DIGITS; i++)
		begin : markerGen
			assign markerMask[dac_loader_pkg::DISPLAY_DIGITS-1-i] = enable_r &&
				(4'(i + 1) >= position_r) && (4'(i + 1) <= 4'(position_r + 4'd2));
		end
	endgenerate

	assign entryValue = 8'(tens_r * 8'd10) + 8'(keyEvent.digit);

	// Keypad selection sequence
	always_comb
	begin
		showMode_nxt = showMode_r;
		enable_nxt = enable_r;
		position_nxt = position_r;
		tens_nxt = tens_r;
		units_nxt = units_r;
		if (keyEvent.press)
		begin
			unique case (keyEvent.code)
				dac_loader_pkg::KEY_CLEAR:
					showMode_nxt = dac_loader_pkg::SHOW_NORMAL;
				dac_loader_pkg::KEY_OFF:
				begin
					enable_nxt = 1'b0;
					showMode_nxt = dac_loader_pkg::SHOW_NORMAL;
				end
				dac_loader_pkg::KEY_FUNCTION:
				begin
					if (showMode_r == dac_loader_pkg::SHOW_STATUS || showMode_r == dac_loader_pkg::SHOW_PARTIAL)
						showMode_nxt = dac_loader_pkg::SHOW_ERROR;
					else
						showMode_nxt = dac_loader_pkg::SHOW_STATUS;
				end
				dac_loader_pkg::KEY_DIGIT:
				begin
					if (showMode_r == dac_loader_pkg::SHOW_STATUS)
					begin
						tens_nxt = keyEvent.digit;
						showMode_nxt = dac_loader_pkg::SHOW_PARTIAL;
					end
					else if (showMode_r == dac_loader_pkg::SHOW_PARTIAL)
					begin
						units_nxt = keyEvent.digit;
						if (entryValue == 8'h00)
						begin
							enable_nxt = 1'b0;
							showMode_nxt = dac_loader_pkg::SHOW_NEW;
						end
						else if (entryValue <= {4'h0, dac_loader_pkg::POSITION_LAST})
						begin
							enable_nxt = 1'b1;
							position_nxt = entryValue[3:0];
							showMode_nxt = dac_loader_pkg::SHOW_NEW;
						end
						else
							showMode_nxt = dac_loader_pkg::SHOW_ERROR;
					end
				end
				default:
				begin
					if (showMode_r == dac_loader_pkg::SHOW_STATUS || showMode_r == dac_loader_pkg::SHOW_PARTIAL)
						showMode_nxt = dac_loader_pkg::SHOW_ERROR;
				end
			endcase
		end
		else if (keyEvent.keyUp && showMode_r == dac_loader_pkg::SHOW_NEW)
			showMode_nxt = dac_loader_pkg::SHOW_NORMAL;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			showMode_r <= dac_loader_pkg::SHOW_NORMAL;
			enable_r <= 1'b0;
			position_r <= 4'h0;
			tens_r <= 4'h0;
			units_r <= 4'h0;
		end
		else
		begin
			showMode_r <= showMode_nxt;
			enable_r <= enable_nxt;
			position_r <= position_nxt;
			tens_r <= tens_nxt;
			units_r <= units_nxt;
		end
	end

	assign startLoad = (seqState_r == SQ_IDLE) && (testSync_r || (pending_r && enable_r));

	// Load sequencer: port A, then port B with the strobe, then the latch
	always_comb
	begin
		seqState_nxt = seqState_r;
		pending_nxt = pending_r;
		wordPend_nxt = wordPend_r;
		ramp_nxt = ramp_r;
		portA_nxt = portA_r;
		portB_nxt = portB_r;
		strobe_nxt = 1'b0;
		latch_nxt = latch_r;
		unique case (seqState_r)
			SQ_IDLE:
			begin
				if (startLoad)
				begin
					pending_nxt = 1'b0;
					seqState_nxt = SQ_LOW;
					if (testSync_r)
					begin
						wordPend_nxt = ramp_r;
						ramp_nxt = bcdInc(ramp_r);
					end
					else
						wordPend_nxt = selectedWord;
				end
			end
			SQ_LOW:
			begin
				portA_nxt = wordPend_r[7:0];
				seqState_nxt = SQ_HIGH;
			end
			SQ_HIGH:
			begin
				portB_nxt = wordPend_r[11:8];
				strobe_nxt = 1'b1;
				seqState_nxt = SQ_IDLE;
			end
		endcase
		if (!enable_r)
			pending_nxt = 1'b0;
		if (displayRefresh && enable_r)
			pending_nxt = 1'b1;
		if (strobe_r)
			latch_nxt = {portB_r, portA_r};
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seqState_r <= SQ_IDLE;
			pending_r <= 1'b0;
			wordPend_r <= dac_loader_pkg::WORD_RESET;
			ramp_r <= dac_loader_pkg::WORD_RESET;
			portA_r <= 8'h00;
			portB_r <= 4'h0;
			strobe_r <= 1'b0;
			latch_r <= dac_loader_pkg::WORD_RESET;
		end
		else
		begin
			seqState_r <= seqState_nxt;
			pending_r <= pending_nxt;
			wordPend_r <= wordPend_nxt;
			ramp_r <= ramp_nxt;
			portA_r <= portA_nxt;
			portB_r <= portB_nxt;
			strobe_r <= strobe_nxt;
			latch_r <= latch_nxt;
		end
	end

	// Outputs
	assign panel.mode = showMode_r;
	assign panel.statusOn = enable_r;
	assign panel.tens = (showMode_r == dac_loader_pkg::SHOW_STATUS) ? position_r / 4'd10 : tens_r;
	assign panel.units = (showMode_r == dac_loader_pkg::SHOW_STATUS) ? position_r % 4'd10 : units_r;
	assign panel.errorCode = (showMode_r == dac_loader_pkg::SHOW_ERROR) ? dac_loader_pkg::ERROR_CODE : 8'h00;
	assign panel.markers = (showMode_r == dac_loader_pkg::SHOW_NORMAL || showMode_r == dac_loader_pkg::SHOW_ERROR)
		? 12'h000 : markerMask;
	assign dacEnabled = enable_r;
	assign dacPosition = position_r;
	assign portLines.portA = portA_r;
	assign portLines.portB = portB_r;
	assign portLines.strobe = strobe_r;
	assign dacWord = latch_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_STROBE_LOADS: assert property (strobe_r |=> dacWord == {$past(portB_r), $past(portA_r)})
		else $error("latch missed strobe");
	AST_LATCH_HOLDS: assert property (!strobe_r |=> $stable(dacWord))
		else $error("latch changed without strobe");
	AST_LOW_FIRST: assert property (seqState_r == SQ_LOW |=> seqState_r == SQ_HIGH ##1 strobe_r)
		else $error("port order broken");
	AST_REFRESH_RELOADS: assert property ((displayRefresh && enable_r && !testSync_r
		&& seqState_r == SQ_IDLE && !keyEvent.press) |-> ##[1:8] strobe_r)
		else $error("refresh not loaded");
	AST_OFF_NO_LOAD: assert property ((!enable_r && !testSync_r) [*3] |-> seqState_r != SQ_LOW)
		else $error("load while disabled");
	AST_ERROR_TEN: assert property ((keyEvent.press && keyEvent.code == dac_loader_pkg::KEY_OTHER
		&& showMode_r == dac_loader_pkg::SHOW_PARTIAL) |=> panel.errorCode == 8'h0A)
		else $error("error code not shown");
	AST_CLEAR_KEEPS: assert property ((keyEvent.press && keyEvent.code == dac_loader_pkg::KEY_CLEAR)
		|=> showMode_r == dac_loader_pkg::SHOW_NORMAL && $stable(enable_r) && $stable(position_r))
		else $error("clear changed selection");
	AST_ZERO_OFF: assert property ((keyEvent.press && keyEvent.code == dac_loader_pkg::KEY_DIGIT
		&& keyEvent.digit == 4'h0 && tens_r == 4'h0 && showMode_r == dac_loader_pkg::SHOW_PARTIAL)
		|=> !enable_r)
		else $error("00 did not disable");
	AST_MARKERS_STAY: assert property (showMode_r == dac_loader_pkg::SHOW_PARTIAL |->
		$stable(position_r) && $stable(enable_r))
		else $error("markers moved early");
	AST_RAMP_WRAP: assert property ((startLoad && testSync_r && ramp_r == 12'h999) |=> ramp_r == 12'h000)
		else $error("ramp did not wrap");
	AST_NONNUMERAL_ZERO: assert property ((startLoad && !testSync_r
		&& charAt(displayChars, 5'({1'b0, position_r} + 5'd1)) > 4'h9) |=> wordPend_r[7:4] == 4'h0)
		else $error("non-numeral not zeroed");
	AST_RELEASE_NORMAL: assert property ((showMode_r == dac_loader_pkg::SHOW_NEW && keyEvent.keyUp
		&& !keyEvent.press) |=> showMode_r == dac_loader_pkg::SHOW_NORMAL)
		else $error("release did not restore display");

	COV_SELECT: cover property (showMode_r == dac_loader_pkg::SHOW_PARTIAL ##1 showMode_r == dac_loader_pkg::SHOW_NEW);
	COV_ERROR: cover property (showMode_r == dac_loader_pkg::SHOW_ERROR);
	COV_STROBE: cover property (strobe_r && enable_r);
	COV_RAMP: cover property (startLoad && testSync_r && ramp_r == 12'h999);

endmodule

// ---- tb/counter_host_model.sv ----
`timescale 1ns/1ns

// Counter side: keypad scanner, display refresh and processor bus
module counter_host_model
(
	// Clock
	input wire logic clock,
	// Keypad and display refresh
	output dac_loader_pkg::keyEvent_type keyEvent,
	output logic displayRefresh,
	// Processor bus
	output logic [15:0] procAddr,
	output logic procRead,
	input wire logic [7:0] procDataOut,
	input wire logic procDataOe,
	// Program loading port
	output logic progWrite,
	output logic [dac_loader_pkg::PROGRAM_ADDR_BITS-1:0] progAddr,
	output logic [7:0] progData
);

	// Idle levels from time zero
	initial
	begin
		keyEvent = '0;
		displayRefresh = 1'b0;
		procAddr = 16'h0000;
		procRead = 1'b0;
		progWrite = 1'b0;
		progAddr = '0;
		progData = 8'h00;
	end

	// One press or release pulse, built whole to keep the struct fields in order
	task automatic keyPulse(input bit isPress, input dac_loader_pkg::keyCode_type code, input logic [3:0] digit);
		@(posedge clock);
		#5;
		keyEvent = dac_loader_pkg::keyEvent_type'({isPress, !isPress, code, digit});
		@(posedge clock);
		#5;
		keyEvent = dac_loader_pkg::keyEvent_type'({2'b00, code, digit});
	endtask

	// One display update pulse
	task automatic refreshPulse;
		@(posedge clock);
		#5;
		displayRefresh = 1'b1;
		@(posedge clock);
		#5;
		displayRefresh = 1'b0;
	endtask

	// Program byte write; data lines show the inverse afterwards so stale values never pass
	task automatic loadByte(input logic [dac_loader_pkg::PROGRAM_ADDR_BITS-1:0] addr, input logic [7:0] data);
		@(posedge clock);
		#5;
		progWrite = 1'b1;
		progAddr = addr;
		progData = data;
		@(posedge clock);
		#5;
		progWrite = 1'b0;
		progData = ~data;
	endtask

	// Read held until the answer edge, then taken and released
	task automatic readByte(input logic [15:0] addr, output logic oe, output logic [7:0] data);
		@(posedge clock);
		#5;
		procRead = 1'b1;
		procAddr = addr;
		@(posedge clock);
		#5;
		oe = procDataOe;
		data = procDataOut;
		procRead = 1'b0;
	endtask

endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns

`define CHECK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nFail++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench;
	// Design signals
	logic clock;
	logic reset_n;
	logic [dac_loader_pkg::DISPLAY_DIGITS-1:0][3:0] displayChars;
	logic rampTestPin;
	dac_loader_pkg::keyEvent_type keyEvent;
	logic displayRefresh;
	logic [15:0] procAddr;
	logic procRead;
	logic [7:0] procDataOut;
	logic procDataOe;
	logic progWrite;
	logic [dac_loader_pkg::PROGRAM_ADDR_BITS-1:0] progAddr;
	logic [7:0] progData;
	dac_loader_pkg::panel_type panel;
	logic dacEnabled;
	logic [3:0] dacPosition;
	dac_loader_pkg::portLines_type portLines;
	logic [11:0] dacWord;
	int nFail;
	int nTests;

	display_digit_dac_loader dut_u (.clock(clock), .reset_n(reset_n), .procAddr(procAddr), .procRead(procRead),
		.procDataOut(procDataOut), .procDataOe(procDataOe), .progWrite(progWrite), .progAddr(progAddr),
		.progData(progData), .displayChars(displayChars), .displayRefresh(displayRefresh), .keyEvent(keyEvent),
		.rampTestPin(rampTestPin), .panel(panel), .dacEnabled(dacEnabled), .dacPosition(dacPosition),
		.portLines(portLines), .dacWord(dacWord));

	counter_host_model hostU (.clock(clock), .keyEvent(keyEvent), .displayRefresh(displayRefresh),
		.procAddr(procAddr), .procRead(procRead), .procDataOut(procDataOut), .procDataOe(procDataOe),
		.progWrite(progWrite), .progAddr(progAddr), .progData(progData));

	// 50 ns clock
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic endSim;
		$display("Comparisons %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Next three-digit BCD count, 999 wraps to 000
	function automatic logic [11:0] bcdInc(input logic [11:0] w);
		logic [11:0] r;
		r = w;
		for (int i = 0; i < 3; i++)
		begin
			if (r[i*4 +: 4] == 4'h9)
				r[i*4 +: 4] = 4'h0;
			else
			begin
				r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
				break;
			end
		end
		return r;
	endfunction

	task automatic press(input dac_loader_pkg::keyCode_type c, input logic [3:0] d);
		hostU.keyPulse(1'b1, c, d);
	endtask

	// Bounded wait for the latch strobe
	task automatic waitStrobe;
		bit seen;
		seen = 1'b0;
		for (int i = 0; i < 20 && !seen; i++)
		begin
			@(posedge clock);
			#5;
			seen = (portLines.strobe === 1'b1);
		end
		if (!seen)
		begin
			nFail++;
			$display("CHECK FAILED strobe expected 1 seen none");
			endSim();
		end
	endtask

	// Refresh, then follow the port writes into the latch
	task automatic loadCheck(input logic [11:0] w);
		hostU.refreshPulse();
		waitStrobe();
		`CHECK("portA", w[7:0], portLines.portA)
		`CHECK("portB", w[11:8], portLines.portB)
		@(posedge clock);
		#5;
		`CHECK("dacWord", w, dacWord)
	endtask

	task automatic readCheck(input logic [15:0] a, input logic oe, input logic [7:0] d);
		logic gotOe;
		logic [7:0] gotData;
		hostU.readByte(a, gotOe, gotData);
		`CHECK("procDataOe", oe, gotOe)
		if (oe)
			`CHECK("procDataOut", d, gotData)
	endtask

	task automatic testReset;
		`CHECK("dacEnabled", 1'b0, dacEnabled)
		`CHECK("dacPosition", 4'h0, dacPosition)
		`CHECK("dacWord", 12'h000, dacWord)
		`CHECK("mode", dac_loader_pkg::SHOW_NORMAL, panel.mode)
		$display("test reset done");
	endtask

	task automatic testWindow;
		hostU.loadByte(10'h000, 8'hA5);
		hostU.loadByte(10'h3FF, 8'h3C);
		readCheck(16'h4800, 1'b1, 8'hA5);
		readCheck(16'h4BFF, 1'b1, 8'h3C);
		readCheck(16'h47FF, 1'b0, 8'h00);
		readCheck(16'h4C00, 1'b0, 8'h00);
		$display("test window done");
	endtask

	task automatic testSelect;
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		`CHECK("mode", dac_loader_pkg::SHOW_STATUS, panel.mode)
		`CHECK("statusOn", 1'b0, panel.statusOn)
		press(dac_loader_pkg::KEY_DIGIT, 4'h0);
		`CHECK("mode", dac_loader_pkg::SHOW_PARTIAL, panel.mode)
		`CHECK("tens", 4'h0, panel.tens)
		press(dac_loader_pkg::KEY_DIGIT, 4'h5);
		`CHECK("mode", dac_loader_pkg::SHOW_NEW, panel.mode)
		`CHECK("dacEnabled", 1'b1, dacEnabled)
		`CHECK("dacPosition", 4'h5, dacPosition)
		`CHECK("markers", 12'h0E0, panel.markers)
		`CHECK("units", 4'h5, panel.units)
		hostU.keyPulse(1'b0, dac_loader_pkg::KEY_DIGIT, 4'h5);
		`CHECK("mode", dac_loader_pkg::SHOW_NORMAL, panel.mode)
		`CHECK("markers", 12'h000, panel.markers)
		$display("test select done");
	endtask

	task automatic testLoad;
		// Positions 5, 6, 7 hold 3, a non-numeral, 7
		displayChars[7] = 4'h3;
		displayChars[6] = 4'hB;
		displayChars[5] = 4'h7;
		loadCheck(12'h307);
		displayChars[6] = 4'h9;
		repeat (6) @(posedge clock);
		#5;
		`CHECK("dacWord", 12'h307, dacWord)
		loadCheck(12'h397);
		$display("test load done");
	endtask

	task automatic testErrorClear;
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		`CHECK("markers", 12'h0E0, panel.markers)
		press(dac_loader_pkg::KEY_OTHER, 4'h0);
		`CHECK("mode", dac_loader_pkg::SHOW_ERROR, panel.mode)
		`CHECK("errorCode", 8'h0A, panel.errorCode)
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h1);
		`CHECK("markers", 12'h0E0, panel.markers)
		press(dac_loader_pkg::KEY_DIGIT, 4'h3);
		`CHECK("mode", dac_loader_pkg::SHOW_ERROR, panel.mode)
		`CHECK("dacPosition", 4'h5, dacPosition)
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h1);
		press(dac_loader_pkg::KEY_CLEAR, 4'h0);
		`CHECK("mode", dac_loader_pkg::SHOW_NORMAL, panel.mode)
		`CHECK("dacEnabled", 1'b1, dacEnabled)
		`CHECK("dacPosition", 4'h5, dacPosition)
		// Status shows the stored position, then a wrong key ends a half entry
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		`CHECK("tens", 4'h0, panel.tens)
		`CHECK("units", 4'h5, panel.units)
		press(dac_loader_pkg::KEY_DIGIT, 4'h1);
		press(dac_loader_pkg::KEY_OTHER, 4'h0);
		`CHECK("errorCode", 8'h0A, panel.errorCode)
		`CHECK("dacPosition", 4'h5, dacPosition)
		$display("test error and clear done");
	endtask

	task automatic testEdgeOff;
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h1);
		press(dac_loader_pkg::KEY_DIGIT, 4'h2);
		`CHECK("dacPosition", 4'hC, dacPosition)
		`CHECK("markers", 12'h001, panel.markers)
		displayChars[0] = 4'h4;
		loadCheck(12'h400);
		press(dac_loader_pkg::KEY_OFF, 4'h0);
		`CHECK("dacEnabled", 1'b0, dacEnabled)
		displayChars[0] = 4'h8;
		hostU.refreshPulse();
		repeat (8)
		begin
			@(posedge clock);
			#5;
			`CHECK("strobe", 1'b0, portLines.strobe)
		end
		`CHECK("dacWord", 12'h400, dacWord)
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h1);
		press(dac_loader_pkg::KEY_FUNCTION, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h0);
		press(dac_loader_pkg::KEY_DIGIT, 4'h0);
		`CHECK("dacEnabled", 1'b0, dacEnabled)
		`CHECK("mode", dac_loader_pkg::SHOW_NEW, panel.mode)
		$display("test edge and off done");
	endtask

	task automatic testRamp;
		logic [11:0] prev;
		bit wrapped;
		wrapped = 1'b0;
		prev = 12'h000;
		rampTestPin = 1'b1;
		for (int i = 0; i < 1003; i++)
		begin
			waitStrobe();
			@(posedge clock);
			#5;
			if (i > 0)
				`CHECK("ramp", bcdInc(prev), dacWord)
			if (i > 0 && prev === 12'h999)
				wrapped = 1'b1;
			prev = dacWord;
		end
		`CHECK("wrap", 1'b1, wrapped)
		rampTestPin = 1'b0;
		$display("test ramp done");
	endtask

	// Main sequence
	initial
	begin
		nFail = 0;
		nTests = 0;
		reset_n = 1'b0;
		rampTestPin = 1'b0;
		displayChars = '1;
		repeat (4) @(posedge clock);
		#5;
		reset_n = 1'b1;
		testReset();
		testWindow();
		testSelect();
		testLoad();
		testErrorClear();
		testEdgeOff();
		testRamp();
		endSim();
	end

endmodule
